// *** bench/bpp_host_model.sv ***
// host microcontroller model for the force-off and sleep pins
`timescale 1ns/1ns
module bpp_host_model (
   input wire logic clk, // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic force_req, // bench wants all fets off
   input wire logic sleep_req, // bench wants shutdown
   output logic fet_force_off_in, // force-off pin
   output logic sleep_request_in // sleep pin
);
   // ==========================================
   // pins low for normal work, changed just after the edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fet_force_off_in <= 1'h0;
         sleep_request_in <= 1'h0;
      end else begin
         fet_force_off_in <= force_req;
         sleep_request_in <= sleep_req;
      end
   end
endmodule // bpp_host_model

// *** bench/tb_bpp_protector.sv ***
// self-checking bench for the battery-pack protector
`timescale 1ns/1ns
module tb_bpp_protector;
   import bpp_pkg::*;
   localparam int PER = 50; // short standby 40 plus sample 10
   localparam int LIMIT = 6000; // cycle ceiling for the run
   logic clk, arst_n, charger, dis_det, pack_ok, force_req, sleep_req, force_w, sleep_w, tk, fc, ds;
   logic [3:0] over, hyst, under, strb;
   logic [2:0] cur, exp;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   int error_cnt = 0, check_count = 0, cyc = 0, base = 0, n;
   // small counts keep each phase 40 cycles or fewer
   bpp_protector #(.STANDBY_CYC(32'h28), .SAMPLE_CYC(32'hA), .CUR_DELAY_CYC(32'h6), .SHORT_DELAY_CYC(32'h4))
   bpp_protector_inst (.clk(clk), .arst_n(arst_n), .cell_over_in(over), .cell_hyst_clear_in(hyst),
      .cell_under_in(under), .charger_detect_in(charger), .discharge_detect_in(dis_det), .pack_ok_in(pack_ok),
      .charge_current_in(cur[0]), .discharge_current_in(cur[1]), .short_current_in(cur[2]),
      .fet_force_off_in(force_w), .sleep_request_in(sleep_w), .trickle_gate_n(tk), .fast_charge_gate_n(fc),
      .discharge_gate_n(ds), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   bpp_host_model bpp_host_model_inst (.clk(clk), .arst_n(arst_n), .force_req(force_req),
      .sleep_req(sleep_req), .fet_force_off_in(force_w), .sleep_request_in(sleep_w));
   // ==========================================
   // clock and hang guard
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         error_cnt++;
         results();
      end
   end
   // ==========================================
   // report, compare and wait helpers
   task automatic results();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_gates(input logic [2:0] e);
      chk_word("gates", {29'h0, e}, {29'h0, tk, fc, ds});
   endtask
   // expected {trickle, fast, discharge}: all off, charge paths off, trickle only, else all on
   function automatic logic [2:0] gates_for(input logic all_off, input logic chg_off, input logic tkl_only);
      return all_off ? 3'h7 : chg_off ? 3'h6 : tkl_only ? 3'h3 : 3'h0;
   endfunction
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   // mid-standby, well away from the sample strobe
   task automatic align();
      do @(posedge clk); while ((cyc - base) % PER != 25);
   endtask
   // ==========================================
   // axi-lite master: hold each channel until its ready
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_ok, w_ok;
      aw_ok = 1'h0;
      w_ok = 1'h0;
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
      do begin
         @(posedge clk);
         if (awready === 1'h1) aw_ok = 1'h1;
         if (wready === 1'h1) w_ok = 1'h1;
         awvalid <= !aw_ok;
         wvalid <= !w_ok;
      end while (!(aw_ok && w_ok));
      while (bvalid !== 1'h1) @(posedge clk);
      rs = bresp;
      bready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] rs);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do @(posedge clk); while (arready !== 1'h1);
      arvalid <= 1'h0;
      do @(posedge clk); while (rvalid !== 1'h1);
      q = rdata;
      rs = rresp;
      rready <= 1'h0;
      @(posedge clk);
   endtask
   // ==========================================
   // main sequence
   initial begin
      {arst_n, charger, dis_det, force_req, sleep_req, awvalid, wvalid, bready, arvalid, rready} = '0;
      {over, hyst, under, cur, awaddr, araddr, wdata} = '0;
      {pack_ok, strb} = 5'h1F;
      n = $urandom(32'hEB3B20F3);
      tick(20);
      chk_gates(3'h7);
      arst_n <= 1'h1;
      base = cyc;
      tick(3);
      chk_gates(3'h0);
      axi_rd(REG_CONTROL, d, r);
      chk_word("control", {31'h0, CTRL_RESET}, d);
      axi_rd(8'h10, d, r);
      chk_word("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_wr(8'h10, 32'h1, r);
      chk_word("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      // byte lane 0 disabled: control must keep its value
      strb <= 4'hE;
      axi_wr(REG_CONTROL, 32'h1, r);
      chk_word("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
      strb <= 4'hF;
      axi_rd(REG_CONTROL, d, r);
      chk_word("control", {31'h0, CTRL_RESET}, d);
      chk_word("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_rd(REG_STATUS, d, r);
      chk_word("mode", 32'h1, {30'h0, d[1:0]});
      align();
      tick(18);
      axi_rd(REG_STATUS, d, r);
      chk_word("mode", 32'h2, {30'h0, d[1:0]});
      // broken run of three, then a full run of four
      align();
      over <= 4'(1 + $urandom % 15);
      tick(3 * PER);
      over <= 4'h0;
      tick(PER);
      over <= 4'(1 + $urandom % 15);
      tick(3 * PER);
      chk_gates(3'h0);
      axi_rd(REG_COUNTS, d, r);
      chk_word("counts", 32'h3, d);
      tick(PER);
      chk_gates(3'h6);
      over <= 4'h0;
      tick(PER);
      chk_gates(3'h0);
      // hysteresis release
      axi_wr(REG_CONTROL, 32'h1, r);
      align();
      over <= 4'(1 + $urandom % 15);
      tick(4 * PER);
      over <= 4'h0;
      tick(PER);
      chk_gates(3'h6);
      hyst <= 4'hF;
      tick(PER);
      chk_gates(3'h0);
      axi_wr(REG_CONTROL, 32'h0, r);
      // undervoltage with, then without, a charger
      align();
      {charger, under} <= {1'h1, 4'(1 + $urandom % 15)};
      tick(4 * PER);
      chk_gates(3'h3);
      charger <= 1'h0;
      tick(2 * PER);
      chk_gates(3'h7);
      axi_rd(REG_STATUS, d, r);
      chk_word("mode", 32'h0, {30'h0, d[1:0]});
      // a charger without pack voltage must not wake the block
      {charger, pack_ok} <= 2'h2;
      tick(3);
      chk_gates(3'h7);
      {charger, under, pack_ok} <= {1'h1, 4'h0, 1'h1};
      @(posedge clk);
      base = cyc;
      align();
      tick(PER);
      chk_gates(3'h0);
      pack_ok <= 1'h0;
      tick(3);
      chk_gates(gates_for(1'h0, 1'h0, 1'h1));
      {charger, pack_ok} <= 2'h1;
      // current faults: charge, discharge, pack short
      for (int k = 0; k < 3; k++) begin
         n = (k == 2) ? 4 : 6;
         exp = gates_for(k != 0, k == 0, 1'h0);
         cur[k] <= 1'h1;
         tick(1 + $urandom % (n - 1));
         cur[k] <= 1'h0;
         tick(3);
         chk_gates(3'h0);
         cur[k] <= 1'h1;
         tick(n + 3);
         cur[k] <= 1'h0;
         tick(3);
         chk_gates(exp);
         axi_rd(REG_STATUS, d, r);
         chk_word("faults", 32'h1 << k, {29'h0, d[6:4]});
         tick(20);
         chk_gates(exp);
         if (k == 0) dis_det <= 1'h1;
         else charger <= 1'h1;
         tick(3);
         {dis_det, charger} <= 2'h0;
         tick(3);
         chk_gates(3'h0);
      end
      // host pins
      force_req <= 1'h1;
      tick(3);
      chk_gates(3'h7);
      {force_req, charger, sleep_req} <= 3'h3;
      tick(4);
      chk_gates(3'h0);
      charger <= 1'h0;
      tick(4);
      chk_gates(3'h7);
      results();
   end
endmodule // tb_bpp_protector

// *** hw/bpp_pkg.sv ***
// constants, timing and register map of the battery-pack protector
package bpp_pkg;
   // ==========================================
   // clock and timing
   localparam int unsigned CLK_PERIOD_NS = 20; // 50 MHz system clock
   localparam int unsigned STANDBY_NS = 79_000_000; // standby phase, 79 ms
   localparam int unsigned SAMPLE_NS = 500_000; // sample phase, 0.5 ms
   localparam int unsigned CUR_DELAY_NS = 3_000_000; // charge/discharge fault qualify, 3 ms
   localparam int unsigned SHORT_DELAY_NS = 450_000; // pack-short qualify, 450 us
   // nominal phase lengths round down, "more than" limits round up
   localparam logic [31:0] STANDBY_CYC = 32'(STANDBY_NS / CLK_PERIOD_NS);
   localparam logic [31:0] SAMPLE_CYC = 32'(SAMPLE_NS / CLK_PERIOD_NS);
   localparam logic [31:0] CUR_DELAY_CYC = 32'((CUR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [31:0] SHORT_DELAY_CYC = 32'((SHORT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // ==========================================
   // sampling
   localparam int unsigned CELLS = 4; // cells in series
   localparam logic [2:0] QUAL_SAMPLES = 3'h4; // consecutive faulty samples to qualify
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] REG_CONTROL = 8'h00; // rw: bit0 hysteresis enable
   localparam logic [7:0] REG_STATUS = 8'h04; // ro: mode, flags, faults, gates
   localparam logic [7:0] REG_COUNTS = 8'h08; // ro: sample counters
   localparam int unsigned CTRL_HYST_BIT = 0; // control: hysteresis release
   localparam logic CTRL_RESET = 1'h0; // control reset value
   localparam logic [1:0] RESP_OKAY = 2'h0; // axi okay
   localparam logic [1:0] RESP_SLVERR = 2'h2; // axi slave error
   // ==========================================
   // operating phases
   typedef enum logic [1:0] {
      BPP_SHUTDOWN,
      BPP_STANDBY,
      BPP_SAMPLE
   } bpp_mode_t;
endpackage

// *** hw/bpp_protector.sv ***
// battery-pack protector control: modes, sampling, fault latches, gate drive, axi-lite registers
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module bpp_protector #(
   parameter logic [31:0] STANDBY_CYC = bpp_pkg::STANDBY_CYC, // standby phase length
   parameter logic [31:0] SAMPLE_CYC = bpp_pkg::SAMPLE_CYC, // sample phase length
   parameter logic [31:0] CUR_DELAY_CYC = bpp_pkg::CUR_DELAY_CYC, // current fault qualify
   parameter logic [31:0] SHORT_DELAY_CYC = bpp_pkg::SHORT_DELAY_CYC, // short fault qualify
   parameter int unsigned CELLS = bpp_pkg::CELLS // cells in series
) (
   input wire logic clk, // 50 MHz clock
   input wire logic arst_n, // async reset, active low
   input wire logic [CELLS-1:0] cell_over_in, // cell above high limit
   input wire logic [CELLS-1:0] cell_hyst_clear_in, // cell below high limit minus hysteresis
   input wire logic [CELLS-1:0] cell_under_in, // cell below low limit
   input wire logic charger_detect_in, // common source above top cell by margin
   input wire logic discharge_detect_in, // top cell above common source by margin
   input wire logic pack_ok_in, // pack voltage above 4.5 V
   input wire logic charge_current_in, // sense over charge limit
   input wire logic discharge_current_in, // sense over discharge limit
   input wire logic short_current_in, // sense over short limit
   input wire logic fet_force_off_in, // host forces all fets off
   input wire logic sleep_request_in, // host requests shutdown
   output logic trickle_gate_n, // trickle fet gate, low = on
   output logic fast_charge_gate_n, // fast-charge fet gate, low = on
   output logic discharge_gate_n, // discharge fet gate, low = on
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read response valid
   input wire logic s_axi_rready // read response ready
);
   import bpp_pkg::*;

   // ==========================================
   // state
   bpp_mode_t mode; // operating phase
   bpp_mode_t next_mode; // phase for next cycle
   logic [31:0] phase_cnt; // cycles spent in current phase
   logic [2:0] over_cnt; // consecutive overvoltage samples
   logic [2:0] under_cnt; // consecutive undervoltage samples
   logic over_flag; // qualified overvoltage held
   logic under_flag; // qualified undervoltage held
   logic [31:0] chg_cnt; // charge comparator run length
   logic [31:0] dis_cnt; // discharge comparator run length
   logic [31:0] sht_cnt; // short comparator run length
   logic chg_fault; // latched charge-current fault
   logic dis_fault; // latched discharge-current fault
   logic sht_fault; // latched pack-short fault
   logic hyst_en; // control: release through hysteresis comparator

   // ==========================================
   // decode
   wire any_over = |cell_over_in; // some cell high
   wire any_under = |cell_under_in; // some cell low
   wire all_hyst_clear = &cell_hyst_clear_in; // every cell below release level
   wire in_normal = (mode != BPP_SHUTDOWN); // standby or sample
   wire standby_done = (mode == BPP_STANDBY) && (phase_cnt == STANDBY_CYC - 32'h1);
   wire sample_strobe = (mode == BPP_SAMPLE) && (phase_cnt == SAMPLE_CYC - 32'h1);
   // released only at the end of a sample; hysteresis variant needs the lower level
   wire over_release = sample_strobe && (hyst_en ? all_hyst_clear : !any_over);
   wire over_qual = sample_strobe && any_over && (over_cnt == QUAL_SAMPLES - 3'h1);
   wire under_qual = sample_strobe && any_under && (under_cnt == QUAL_SAMPLES - 3'h1);
   wire under_release = sample_strobe && !any_under;
   wire sleep_cause = sleep_request_in && !charger_detect_in;
   wire uv_cause = (under_qual || under_flag) && !charger_detect_in;
   wire wake_cause = charger_detect_in && pack_ok_in;
   wire deep_dis = charger_detect_in && !pack_ok_in; // deep discharge, trickle only
   // comparators qualify only in normal mode, both phases
   wire chg_trip = in_normal && charge_current_in && (chg_cnt >= CUR_DELAY_CYC);
   wire dis_trip = in_normal && discharge_current_in && (dis_cnt >= CUR_DELAY_CYC);
   wire sht_trip = in_normal && short_current_in && (sht_cnt >= SHORT_DELAY_CYC);
   // off requests per gate
   wire common_off = fet_force_off_in || (mode == BPP_SHUTDOWN) || dis_fault || sht_fault;
   wire next_trickle_n = common_off || over_flag || chg_fault || (under_flag && !charger_detect_in);
   wire next_fast_n = common_off || over_flag || chg_fault || under_flag || deep_dis;
   wire next_dis_n = common_off || under_flag || deep_dis;

   // ==========================================
   // phase sequencer
   always_comb begin
      next_mode = mode;
      case (mode)
         BPP_SHUTDOWN: begin
            if (wake_cause) begin
               next_mode = BPP_STANDBY;
            end
         end
         BPP_STANDBY: begin
            if (sleep_cause || uv_cause) begin
               next_mode = BPP_SHUTDOWN;
            end else if (standby_done) begin
               next_mode = BPP_SAMPLE;
            end
         end
         BPP_SAMPLE: begin
            if (sleep_cause || uv_cause) begin
               next_mode = BPP_SHUTDOWN;
            end else if (sample_strobe) begin
               next_mode = BPP_STANDBY;
            end
         end
         default: begin
            next_mode = BPP_SHUTDOWN;
         end
      endcase
   end

   // phase register and its cycle counter
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode <= BPP_STANDBY;
         phase_cnt <= 32'h0;
      end else begin
         mode <= next_mode;
         phase_cnt <= (next_mode != mode) ? 32'h0 : phase_cnt + 32'h1;
      end
   end

   // ==========================================
   // consecutive sample counters and voltage flags
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         over_cnt <= 3'h0;
         under_cnt <= 3'h0;
         over_flag <= 1'h0;
         under_flag <= 1'h0;
      end else if (mode == BPP_SHUTDOWN) begin
         // a fresh start after wake, voltages are re-qualified
         over_cnt <= 3'h0;
         under_cnt <= 3'h0;
         over_flag <= 1'h0;
         under_flag <= 1'h0;
      end else if (sample_strobe) begin
         // saturate at the qualify count; a clean sample restarts the run
         over_cnt <= !any_over ? 3'h0 : (over_qual || over_flag) ? QUAL_SAMPLES : over_cnt + 3'h1;
         under_cnt <= !any_under ? 3'h0 : (under_qual || under_flag) ? QUAL_SAMPLES : under_cnt + 3'h1;
         over_flag <= over_qual || (over_flag && !over_release);
         under_flag <= under_qual || (under_flag && !under_release);
      end
   end

   // ==========================================
   // current fault qualification, one per comparator
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chg_cnt <= 32'h0;
         dis_cnt <= 32'h0;
         sht_cnt <= 32'h0;
      end else begin
         // a dropout restarts the qualify time; counts stop at the limit
         chg_cnt <= (in_normal && charge_current_in) ? (chg_trip ? chg_cnt : chg_cnt + 32'h1) : 32'h0;
         dis_cnt <= (in_normal && discharge_current_in) ? (dis_trip ? dis_cnt : dis_cnt + 32'h1) : 32'h0;
         sht_cnt <= (in_normal && short_current_in) ? (sht_trip ? sht_cnt : sht_cnt + 32'h1) : 32'h0;
      end
   end

   // fault latches; a trip in the clearing cycle wins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chg_fault <= 1'h0;
         dis_fault <= 1'h0;
         sht_fault <= 1'h0;
      end else begin
         chg_fault <= chg_trip || (chg_fault && !discharge_detect_in);
         dis_fault <= dis_trip || (dis_fault && !charger_detect_in);
         sht_fault <= sht_trip || (sht_fault && !charger_detect_in);
      end
   end

   // ==========================================
   // gate drivers, registered, high means fet off
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         trickle_gate_n <= 1'h1;
         fast_charge_gate_n <= 1'h1;
         discharge_gate_n <= 1'h1;
      end else begin
         trickle_gate_n <= next_trickle_n;
         fast_charge_gate_n <= next_fast_n;
         discharge_gate_n <= next_dis_n;
      end
   end

   // ==========================================
   // axi4-lite slave: one write and one read at a time
   logic aw_held; // write address captured
   logic w_held; // write data captured
   logic [7:0] aw_addr; // captured write address
   logic [31:0] w_data; // captured write data
   logic [3:0] w_strb; // captured byte enables
   wire wr_fire = aw_held && w_held && !s_axi_bvalid; // both halves present
   wire wr_ctrl = (aw_addr == REG_CONTROL); // control is the only writable word
   wire wr_ok = wr_ctrl || (aw_addr == REG_STATUS) || (aw_addr == REG_COUNTS);
   wire rd_fire = s_axi_arvalid && s_axi_arready; // read address taken
   wire rd_ok = (s_axi_araddr == REG_CONTROL) || (s_axi_araddr == REG_STATUS) || (s_axi_araddr == REG_COUNTS);
   wire [31:0] status_word = {22'h0, discharge_gate_n, fast_charge_gate_n, trickle_gate_n,
      sht_fault, dis_fault, chg_fault, under_flag, over_flag, 2'(mode)};
   wire [31:0] counts_word = {25'h0, under_cnt, 1'h0, over_cnt};
   wire [31:0] rd_word = (s_axi_araddr == REG_CONTROL) ? {31'h0, hyst_en} :
      (s_axi_araddr == REG_STATUS) ? status_word :
      (s_axi_araddr == REG_COUNTS) ? counts_word : 32'h0;

   // write channels, taken in either order
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_held <= 1'h0;
         w_held <= 1'h0;
         aw_addr <= 8'h0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'h1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'h0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'h1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'h0;
         end
      end
   end

   // write response and control register; status words ignore writes
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_awready <= 1'h0;
         s_axi_wready <= 1'h0;
         s_axi_bvalid <= 1'h0;
         s_axi_bresp <= RESP_OKAY;
         hyst_en <= CTRL_RESET;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
         if (wr_fire) begin
            s_axi_bvalid <= 1'h1;
            s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            if (wr_ctrl && w_strb[0]) begin
               hyst_en <= w_data[CTRL_HYST_BIT];
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'h0;
         end
      end
   end

   // read channel, answer the cycle after the address
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_arready <= 1'h0;
         s_axi_rvalid <= 1'h0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'h1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'h0;
         end
      end
   end

   // ==========================================
   // checks
   property p_sleep_enters;
      @(posedge clk) disable iff (!arst_n)
         (in_normal && sleep_request_in && !charger_detect_in) |=> (mode == BPP_SHUTDOWN);
   endproperty
   a_sleep_enters: assert property (p_sleep_enters) else $error("sleep request did not shut down");

   property p_shutdown_gates;
      @(posedge clk) disable iff (!arst_n)
         (mode == BPP_SHUTDOWN) |=> (trickle_gate_n && fast_charge_gate_n && discharge_gate_n);
   endproperty
   a_shutdown_gates: assert property (p_shutdown_gates) else $error("gate on during shutdown");

   property p_wake;
      @(posedge clk) disable iff (!arst_n)
         (mode == BPP_SHUTDOWN && charger_detect_in && pack_ok_in) |=> (mode == BPP_STANDBY);
   endproperty
   a_wake: assert property (p_wake) else $error("no wake with charger and pack ok");

   property p_standby_len;
      @(posedge clk) disable iff (!arst_n)
         (mode == BPP_SAMPLE && $past(mode) == BPP_STANDBY) |-> ($past(phase_cnt) == STANDBY_CYC - 32'h1);
   endproperty
   a_standby_len: assert property (p_standby_len) else $error("standby phase wrong length");

   property p_sample_len;
      @(posedge clk) disable iff (!arst_n)
         (mode == BPP_STANDBY && $past(mode) == BPP_SAMPLE) |-> ($past(phase_cnt) == SAMPLE_CYC - 32'h1);
   endproperty
   a_sample_len: assert property (p_sample_len) else $error("sample phase wrong length");

   property p_over_qual;
      @(posedge clk) disable iff (!arst_n) over_qual |=> over_flag ##1 (fast_charge_gate_n && trickle_gate_n);
   endproperty
   a_over_qual: assert property (p_over_qual) else $error("overvoltage did not stop charge");

   property p_clean_reset;
      @(posedge clk) disable iff (!arst_n)
         (sample_strobe && !any_over && !any_under) |=> (over_cnt == 3'h0 && under_cnt == 3'h0);
   endproperty
   a_clean_reset: assert property (p_clean_reset) else $error("clean sample kept a count");

   property p_chg_fault;
      @(posedge clk) disable iff (!arst_n) chg_trip |=> chg_fault ##1 (fast_charge_gate_n && trickle_gate_n);
   endproperty
   a_chg_fault: assert property (p_chg_fault) else $error("charge fault not latched");

   property p_sht_latch;
      @(posedge clk) disable iff (!arst_n) (sht_fault && !charger_detect_in) |=> sht_fault;
   endproperty
   a_sht_latch: assert property (p_sht_latch) else $error("short fault cleared without charger");

   property p_force_off;
      @(posedge clk) disable iff (!arst_n)
         fet_force_off_in |=> (trickle_gate_n && fast_charge_gate_n && discharge_gate_n);
   endproperty
   a_force_off: assert property (p_force_off) else $error("force-off left a gate on");

   property p_all_on;
      @(posedge clk) disable iff (!arst_n)
         !(next_trickle_n | next_fast_n | next_dis_n) |=> !(trickle_gate_n | fast_charge_gate_n | discharge_gate_n);
   endproperty
   a_all_on: assert property (p_all_on) else $error("gate off without a cause");
endmodule // bpp_protector
